// [src/mdw_pkg.sv]
// package for the module-disable write lock: register map, fields, reset values,
// unlock keys, bus request carrier and unlock sequence states.
// assumes a single 10 MHz clock domain and a simple strobe register port.
package mdw_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------------------
  localparam int          MDW_AW         = 8;
  localparam logic [7:0]  MDW_SYS_CFG    = 8'h00; // system_config_reg
  localparam logic [7:0]  MDW_UNLOCK_KEY = 8'h04; // write-only key port
  localparam logic [7:0]  MDW_DEV_CFG3   = 8'h08; // device_config_word_three
  localparam logic [7:0]  MDW_MD_BASE    = 8'h10; // module_disable_regs[0]
  localparam int          MDW_MD_NUM     = 4;

  // ---------------------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          MDW_LOCK_BIT    = 12;  // disable_write_lock
  localparam int          MDW_ONESHOT_BIT = 28;  // lock_one_shot_cfg
  localparam logic        MDW_LOCK_RST    = 1'b1;
  localparam logic [31:0] MDW_CFG3_RST    = 32'hffff_ffff; // most cautious until sampled
  localparam logic [31:0] MDW_MD_RST      = 32'h0000_0000;
  localparam logic [1:0]  MDW_CFG_LOADED  = 2'h3; // sync stages plus capture

  // unlock keys, two writes in consecutive accesses
  localparam logic [31:0] MDW_KEY_A = 32'haa99_6655;
  localparam logic [31:0] MDW_KEY_B = 32'h5566_99aa;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mdw_req_t;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_HALF,
    UNL_OPEN
  } mdw_unl_t;

endpackage : mdw_pkg

// [src/mdw_lock_bank.sv]
// module-disable register bank with write lock, unlock sequence and one-shot lock.
// assumes a register master on clk that never asserts wr and rd together,
// and a nonvolatile configuration word that is quiet around reset release.
`timescale 1ns/100ps
module mdw_lock_bank
  import mdw_pkg::*;
#(
  parameter int NUM_MD = MDW_MD_NUM
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // register port
  input  wire mdw_req_t            req,
  output logic [31:0]              rdata,
  // nonvolatile configuration word
  input  wire logic [31:0]         nvm_cfg_word,
  // block outputs
  output logic [NUM_MD*32-1:0]     module_disable_regs,
  output logic                     disable_write_lock
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  // one struct keeps reset and next-state handling in one place
  typedef struct packed {
    logic                  lock;
    logic                  set_once;
    mdw_unl_t              unl;
    logic [31:0]           cfg_s1;
    logic [31:0]           cfg_s2;
    logic [31:0]           cfg;
    logic [1:0]            cfg_cnt;
    logic [NUM_MD*32-1:0]  md;
    logic [31:0]           rdata;
  } mdw_state_t;

  mdw_state_t st;
  mdw_state_t next_st;

  // index of a module-disable register, or NUM_MD when not hit
  function automatic int md_index(input logic [7:0] a);
    int k;
    k = NUM_MD;
    for (int i = 0; i < NUM_MD; i++) begin
      if (a == MDW_MD_BASE + 8'(4 * i)) begin
        k = i;
      end
    end
    return k;
  endfunction : md_index

  logic oneshot;
  logic frozen;
  int   widx;
  int   ridx;

  // frozen: one-shot armed and lock set once; only reset thaws it
  assign oneshot = st.cfg[MDW_ONESHOT_BIT];
  assign frozen  = oneshot && st.set_once && st.lock;
  assign widx    = md_index(req.addr);
  assign ridx    = md_index(req.addr);

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st        = st;
    // config word: two sync stages, then one capture, never again until reset
    next_st.cfg_s1 = nvm_cfg_word;
    next_st.cfg_s2 = st.cfg_s1;
    if (st.cfg_cnt != MDW_CFG_LOADED) begin
      next_st.cfg_cnt = st.cfg_cnt + 2'h1;
      if (st.cfg_cnt == MDW_CFG_LOADED - 2'h1) begin
        next_st.cfg = st.cfg_s2;
      end
    end

    // unlock sequence: any access other than the second key aborts it
    // aborting on reads too keeps a stray access from leaving a half-open door
    if (req.wr || req.rd) begin
      case (st.unl)
        UNL_IDLE: begin
          if (req.wr && req.addr == MDW_UNLOCK_KEY && req.wdata == MDW_KEY_A && !frozen) begin
            next_st.unl = UNL_HALF;
          end
        end
        UNL_HALF: begin
          if (req.wr && req.addr == MDW_UNLOCK_KEY && req.wdata == MDW_KEY_B && !frozen) begin
            next_st.unl = UNL_OPEN;
          end else begin
            next_st.unl = UNL_IDLE;
          end
        end
        UNL_OPEN: begin
          // open until spent by a write to the config register or a new key
          if (req.wr && (req.addr == MDW_SYS_CFG || req.addr == MDW_UNLOCK_KEY)) begin
            next_st.unl = UNL_IDLE;
          end
        end
        default: begin
          next_st.unl = UNL_IDLE;
        end
      endcase
    end

    // lock bit: needs an open sequence; one-shot forbids clearing after a set
    // a set always goes through, only a clear can be refused
    if (req.wr && req.addr == MDW_SYS_CFG && st.unl == UNL_OPEN) begin
      if (req.wdata[MDW_LOCK_BIT]) begin
        next_st.lock     = 1'b1;
        next_st.set_once = 1'b1;
      end else if (!(oneshot && st.set_once)) begin
        next_st.lock = 1'b0;
      end
    end

    // module-disable writes are accepted silently but dropped while locked
    if (req.wr && widx < NUM_MD && !st.lock) begin
      next_st.md[widx*32 +: 32] = req.wdata;
    end

    // read data stands one cycle after the strobe only
    next_st.rdata = 32'h0000_0000;
    if (req.rd) begin
      if (req.addr == MDW_SYS_CFG) begin
        next_st.rdata[MDW_LOCK_BIT] = st.lock;
      end else if (req.addr == MDW_DEV_CFG3) begin
        next_st.rdata = st.cfg;
      end else if (ridx < NUM_MD) begin
        next_st.rdata = st.md[ridx*32 +: 32];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st          <= '0;
      st.lock     <= MDW_LOCK_RST;
      st.unl      <= UNL_IDLE;
      // all ones until sampled, so one-shot counts as armed early
      st.cfg      <= MDW_CFG3_RST;
      st.md       <= {NUM_MD{MDW_MD_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign rdata               = st.rdata;
  assign module_disable_regs = st.md;
  assign disable_write_lock  = st.lock;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  // every property samples on clk and stands down while reset is low
  AST_LOCK_DROPS: assert property (@(posedge clk) disable iff (!arst_n)
    st.lock && req.wr && widx < NUM_MD |=> $stable(st.md))
    else $error("write reached a locked module-disable register");

  AST_UNLOCKED_WRITES: assert property (@(posedge clk) disable iff (!arst_n)
    !st.lock && req.wr && widx < NUM_MD && req.wdata != st.md[widx*32 +: 32] |=> !$stable(st.md))
    else $error("unlocked module-disable write was lost");

  AST_NEEDS_KEY: assert property (@(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == MDW_SYS_CFG && st.unl != UNL_OPEN |=> $stable(st.lock))
    else $error("lock changed without unlock sequence");

  AST_ONE_SHOT_HOLDS: assert property (@(posedge clk) disable iff (!arst_n)
    oneshot && st.set_once && st.lock |=> st.lock)
    else $error("one-shot lock was cleared");

  AST_NO_OPEN_FROZEN: assert property (@(posedge clk) disable iff (!arst_n)
    frozen && st.unl != UNL_OPEN |=> st.unl != UNL_OPEN)
    else $error("unlock sequence opened while frozen");

  AST_RESET_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(st.lock) |-> !$past(oneshot && st.set_once))
    else $error("lock cleared under one-shot without reset");

  AST_DEFAULT_LOCKED: assert property (@(posedge clk) disable iff (!arst_n)
    st.cfg_cnt == 2'h0 |-> st.lock ##1 st.lock)
    else $error("lock not set after reset");

  AST_MULTI_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    !oneshot && st.unl == UNL_OPEN && req.wr && req.addr == MDW_SYS_CFG
      && !req.wdata[MDW_LOCK_BIT] |=> !st.lock)
    else $error("lock not cleared with one-shot off");

  AST_CFG_READ_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    st.cfg_cnt == MDW_CFG_LOADED |=> $stable(st.cfg))
    else $error("configuration word changed after capture");

  AST_CFG_CAPTURE: assert property (@(posedge clk) disable iff (!arst_n)
    st.cfg_cnt == 2'h2 |=> st.cfg == $past(st.cfg_s2))
    else $error("configuration word not captured");

  AST_CFG_READBACK: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && req.addr == MDW_DEV_CFG3 |=> rdata == $past(st.cfg))
    else $error("configuration word read back wrong");

  AST_LOCK_READBACK: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && req.addr == MDW_SYS_CFG |=> rdata[MDW_LOCK_BIT] == $past(st.lock))
    else $error("lock bit read back wrong");

  AST_KEY_REFUSED: assert property (@(posedge clk) disable iff (!arst_n)
    frozen && req.wr && req.addr == MDW_UNLOCK_KEY |=> st.unl == UNL_IDLE)
    else $error("key accepted while frozen");

  AST_SINGLE_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    oneshot && !st.set_once && st.unl == UNL_OPEN && req.wr && req.addr == MDW_SYS_CFG
      && !req.wdata[MDW_LOCK_BIT] |=> !st.lock)
    else $error("first clear under one-shot refused");

  AST_SET_MARKS: assert property (@(posedge clk) disable iff (!arst_n)
    st.unl == UNL_OPEN && req.wr && req.addr == MDW_SYS_CFG && req.wdata[MDW_LOCK_BIT] |=> st.lock && st.set_once)
    else $error("lock set not recorded");

endmodule : mdw_lock_bank

// [verif/tb_module_disable_write_lock.sv]
// self-checking bench for the module-disable write lock bank.
// assumes the bench is the only register master and drives nvm_cfg_word itself.
`timescale 1ns/100ps
module tb_module_disable_write_lock;
  import mdw_pkg::*;
  // ---------------------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------------------
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  mdw_req_t              req = '0;
  logic [31:0]           rdata;
  // one-shot off, reserved positions all ones
  logic [31:0]           nvm_cfg_word = 32'hefff_1234;
  logic [MDW_MD_NUM*32-1:0] module_disable_regs;
  logic                  disable_write_lock;
  int                    mismatches = 0;
  int                    check_count = 0;

  mdw_lock_bank u_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .nvm_cfg_word(nvm_cfg_word),
    .module_disable_regs(module_disable_regs), .disable_write_lock(disable_write_lock));

  // 100 ns period
  always #50 clk = ~clk;
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk
  // strobes stay up across back-to-back calls, so no double assignment per edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr
  task automatic idle();
    @(posedge clk);
    req <= '0;
    @(negedge clk);
  endtask : idle
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask : rd
  task automatic unlock_set(input logic v);
    wr(MDW_UNLOCK_KEY, MDW_KEY_A);
    wr(MDW_UNLOCK_KEY, MDW_KEY_B);
    wr(MDW_SYS_CFG, 32'(v) << MDW_LOCK_BIT);
    idle();
  endtask : unlock_set
  // reset with a new config word; waits past the capture edges
  task automatic do_reset(input logic [31:0] cfg);
    @(posedge clk);
    nvm_cfg_word <= cfg;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("lock_rerst", 32'h1, 32'(disable_write_lock));
  endtask : do_reset
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_locked();
    chk("lock_rst", 32'h1, 32'(disable_write_lock));
    chk("md0_rst", MDW_MD_RST, module_disable_regs[31:0]);
    wr(8'h10, 32'h1234_5678);
    idle();
    chk("md0_locked", MDW_MD_RST, module_disable_regs[31:0]);
    wr(MDW_SYS_CFG, 32'h0);
    idle();
    chk("lock_nokey", 32'h1, 32'(disable_write_lock));
    // an access between the two keys aborts the sequence
    wr(MDW_UNLOCK_KEY, MDW_KEY_A);
    rd(MDW_SYS_CFG, 32'h0000_1000, "syscfg_rd");
    wr(MDW_UNLOCK_KEY, MDW_KEY_B);
    wr(MDW_SYS_CFG, 32'h0);
    idle();
    chk("lock_abort", 32'h1, 32'(disable_write_lock));
  endtask : t_locked
  task automatic t_multi();
    rd(MDW_DEV_CFG3, 32'hefff_1234, "cfg3_rd");
    wr(MDW_DEV_CFG3, 32'h0);
    idle();
    rd(MDW_DEV_CFG3, 32'hefff_1234, "cfg3_ro");
    unlock_set(1'b0);
    chk("lock_clr", 32'h0, 32'(disable_write_lock));
    wr(8'h1c, 32'ha5a5_0f0f);
    idle();
    chk("md3_open", 32'ha5a5_0f0f, module_disable_regs[127:96]);
    rd(8'h1c, 32'ha5a5_0f0f, "md3_rd");
    unlock_set(1'b1);
    chk("lock_set", 32'h1, 32'(disable_write_lock));
    unlock_set(1'b0);
    chk("lock_reclr", 32'h0, 32'(disable_write_lock));
  endtask : t_multi
  task automatic t_oneshot();
    do_reset(32'hffff_5678);
    rd(MDW_DEV_CFG3, 32'hffff_5678, "cfg3_os");
    unlock_set(1'b0);
    chk("os_clr", 32'h0, 32'(disable_write_lock));
    unlock_set(1'b1);
    unlock_set(1'b0);
    chk("os_frozen", 32'h1, 32'(disable_write_lock));
    wr(8'h10, 32'h0bad_cafe);
    idle();
    chk("os_md0", MDW_MD_RST, module_disable_regs[31:0]);
    do_reset(32'hffff_5678);
    unlock_set(1'b0);
    chk("os_rst_clr", 32'h0, 32'(disable_write_lock));
    wr(8'h10, 32'h0000_00c3);
    idle();
    chk("os_md0_open", 32'h0000_00c3, module_disable_regs[31:0]);
  endtask : t_oneshot
  // ---------------------------------------------------------------------------
  // verdict, sequence and watchdog
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    t_locked();
    t_multi();
    t_oneshot();
    test_done();
  end
  // roughly 80 cycles expected; generous margin
  initial begin
    #(2000 * 100);
    mismatches++;
    test_done();
  end
endmodule : tb_module_disable_write_lock
